// file: status_summary_cfg.svh
`ifndef STATUS_SUMMARY_CFG_SVH
`define STATUS_SUMMARY_CFG_SVH
`define OFS_GENERAL_INPUT_LEVELS 16'h020c
`define OFS_INTERRUPT_SUMMARY 16'h020d
`define OFS_BOOT_LOAD_ERRORS 16'h0210
`define OFS_BOOT_LOAD_DONE 16'h0211
`define OFS_ALARM_STATUS 16'h0200
`define OFS_ALARM_ENABLE 16'h0079
`define BIT_SUMMARY 0
`define BIT_BOOT_READ_FAILED 0
`define BIT_BOOT_CRC_ERROR 1
`define BIT_BOOT_READ_DONE 0
`define RST_ALARM_ENABLE 8'h00
`define RST_ALARM_STATUS 8'h00
`endif

// file: status_summary_pkg.sv
package status_summary_pkg;
  typedef enum logic [2:0] {
    sel_none,
    sel_inputs,
    sel_summary,
    sel_errors,
    sel_done,
    sel_alarm,
    sel_enable
  } reg_sel_t;
endpackage

// file: sticky_alarm_bit.sv
`timescale 1ns/1ns
`default_nettype none
module sticky_alarm_bit (
  input wire logic clk,
  input wire logic reset,
  input wire logic alarm,
  input wire logic clear,
  output var logic flag
);
  always_ff @(posedge clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (alarm) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule // sticky_alarm_bit
`default_nettype wire

// file: status_summary_registers.sv
// Function
// - A read-only four-bit field returns the live levels of the four general input pins.
// - The summary bit reads one and the interrupt pin goes low while any enabled sticky alarm is set.
// - With no enabled sticky alarm set, the summary bit reads zero and the pin is released.
// - A boot CRC error flag is set on checksum mismatch and only reset clears it.
// - A boot read failure flag is set when the EEPROM read fails and holds until reset.
// - A boot done flag is set when the EEPROM read cycle completes and holds until reset.
// - Each sticky alarm bit is set by its alarm, holds, and clears only on a write of one or on reset.
// - A sticky alarm bit feeds the summary only while its enable bit is one.
`timescale 1ns/1ns
`default_nettype none
`include "status_summary_cfg.svh"
module status_summary_registers #(
  parameter int ALARMS = 8,
  parameter int INPUTS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Pins and events
  input wire logic [3:0] general_input_level,
  input wire logic [7:0] alarm_event,
  input wire logic boot_crc_mismatch,
  input wire logic boot_read_error,
  input wire logic boot_read_complete,
  output logic irq_pin_n
);
  // Only the documented widths are served; other values are refused.
  if (ALARMS != 8) begin : g_alarms_check
    $error("status_summary_registers serves only ALARMS=8");
  end
  if (INPUTS != 4) begin : g_inputs_check
    $error("status_summary_registers serves only INPUTS=4");
  end

  // Alarm registers.
  logic [7:0] alarm_enable;
  logic [7:0] alarm_status;
  logic [7:0] enabled_status;

  // Boot flags.
  logic boot_crc_error;
  logic boot_read_failed;
  logic boot_read_done;

  // Summary and read path.
  logic any_enabled;
  logic summary;
  logic next_summary;
  logic next_irq_pin_n;
  logic [7:0] summary_word;
  logic [7:0] errors_word;
  logic [7:0] done_word;
  logic [7:0] next_rdata;
  status_summary_pkg::reg_sel_t sel;

  // Address decode.
  logic hit_inputs;
  logic hit_summary;
  logic hit_errors;
  logic hit_done;
  logic hit_status;
  logic hit_enable;
  assign hit_inputs = reg_addr == `OFS_GENERAL_INPUT_LEVELS;
  assign hit_summary = reg_addr == `OFS_INTERRUPT_SUMMARY;
  assign hit_errors = reg_addr == `OFS_BOOT_LOAD_ERRORS;
  assign hit_done = reg_addr == `OFS_BOOT_LOAD_DONE;
  assign hit_status = reg_addr == `OFS_ALARM_STATUS;
  assign hit_enable = reg_addr == `OFS_ALARM_ENABLE;

  // The four status registers get no write strobe, so writes to them fall away.
  // writes ignored
  logic write_status;
  logic write_enable;
  logic [7:0] clear_mask;
  assign write_status = reg_write && hit_status;
  assign write_enable = reg_write && hit_enable;
  assign clear_mask = write_status ? reg_wdata : 8'h00;

  genvar i;
  generate
    for (i = 0; i < ALARMS; i++) begin : g_alarm
      sticky_alarm_bit u_bit (
        .clk(clk),
        .reset(reset),
        .alarm(alarm_event[i]),
        .clear(clear_mask[i]),
        .flag(alarm_status[i])
      );
    end
  endgenerate

  assign enabled_status = alarm_status & alarm_enable;
  assign any_enabled = |enabled_status;

  // Pin and bit share one source, so software never sees them disagree.
  // summary source
  assign next_summary = any_enabled;
  assign next_irq_pin_n = ~any_enabled;

  // Summary and pin are each registered from any_enabled in their own flip-flop; one cycle lag.
  always_ff @(posedge clk) begin
    if (reset) begin
      summary <= 1'b0;
    end else begin
      summary <= next_summary;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_pin_n <= 1'b1;
    end else begin
      irq_pin_n <= next_irq_pin_n;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_enable <= `RST_ALARM_ENABLE;
    end else if (write_enable) begin
      alarm_enable <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      boot_crc_error <= 1'b0;
    end else if (boot_crc_mismatch) begin
      boot_crc_error <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      boot_read_failed <= 1'b0;
    end else if (boot_read_error) begin
      boot_read_failed <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      boot_read_done <= 1'b0;
    end else if (boot_read_complete) begin
      boot_read_done <= 1'b1;
    end
  end

  // Register select.
  assign sel = hit_inputs ? status_summary_pkg::sel_inputs :
               hit_summary ? status_summary_pkg::sel_summary :
               hit_errors ? status_summary_pkg::sel_errors :
               hit_done ? status_summary_pkg::sel_done :
               hit_status ? status_summary_pkg::sel_alarm :
               hit_enable ? status_summary_pkg::sel_enable : status_summary_pkg::sel_none;

  // Reserved bits read zero so software reading them back sees a fixed value.
  always_comb begin
    summary_word = 8'h00;
    summary_word[`BIT_SUMMARY] = summary;
  end

  always_comb begin
    errors_word = 8'h00;
    errors_word[`BIT_BOOT_CRC_ERROR] = boot_crc_error;
    errors_word[`BIT_BOOT_READ_FAILED] = boot_read_failed;
  end

  always_comb begin
    done_word = 8'h00;
    done_word[`BIT_BOOT_READ_DONE] = boot_read_done;
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (sel)
      status_summary_pkg::sel_inputs: begin
        next_rdata = {4'h0, general_input_level};
      end
      status_summary_pkg::sel_summary: begin
        next_rdata = summary_word;
      end
      status_summary_pkg::sel_errors: begin
        next_rdata = errors_word;
      end
      status_summary_pkg::sel_done: begin
        next_rdata = done_word;
      end
      status_summary_pkg::sel_alarm: begin
        next_rdata = alarm_status;
      end
      status_summary_pkg::sel_enable: begin
        next_rdata = alarm_enable;
      end
      status_summary_pkg::sel_none: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // status_summary_registers
`default_nettype wire

// file: status_summary_registers_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module status_summary_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Pins and events
  input wire logic [3:0] general_input_level,
  input wire logic [7:0] alarm_event,
  input wire logic boot_crc_mismatch,
  input wire logic boot_read_error,
  input wire logic boot_read_complete,
  input wire logic irq_pin_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] st, en;
  logic [2:0] bt;
  wire rd = reg_read;
  // Set wins over a clear in the same cycle.
  always_ff @(posedge clk) st <= reset ? 8'h00 : st & ~(reg_write &&
    reg_addr == 16'h0200 ? reg_wdata : 8'h00) | alarm_event;
  always_ff @(posedge clk) en <= reset ? 8'h00 :
    reg_write && reg_addr == 16'h0079 ? reg_wdata : en;
  always_ff @(posedge clk) bt <= reset ? 3'h0 :
    bt | {boot_crc_mismatch, boot_read_error, boot_read_complete};
  gpi_read_a: assert property (
    rd && reg_addr == 16'h020c |=> reg_rdata == {4'h0, $past(general_input_level)})
    else $error("input read");
  irq_low_a: assert property (|$past(st & en) |-> !irq_pin_n)
    else $error("pin not low");
  irq_release_a: assert property (!(|$past(st & en)) |-> irq_pin_n)
    else $error("pin not released");
  summary_read_a: assert property (
    rd && reg_addr == 16'h020d |=> reg_rdata == {7'h0, |$past(st & en, 2)})
    else $error("summary read");
  boot_errors_a: assert property (
    rd && reg_addr == 16'h0210 |=> reg_rdata == {6'h0, $past(bt[2:1])})
    else $error("errors read");
  boot_done_a: assert property (
    rd && reg_addr == 16'h0211 |=> reg_rdata == {7'h0, $past(bt[0])})
    else $error("done read");
  alarm_read_a: assert property (
    rd && reg_addr == 16'h0200 |=> reg_rdata == $past(st)) else $error("status read");
  enable_read_a: assert property (
    rd && reg_addr == 16'h0079 |=> reg_rdata == $past(en)) else $error("enable read");
endmodule // status_summary_checker
`default_nettype wire

// file: status_summary_registers_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("Error %0t mismatch %h", $time, a); end end
module status_summary_registers_bench;
  logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, irq_pin_n;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, alarm_event = 8'h00, reg_rdata, q;
  logic [3:0] general_input_levels = 4'h0;
  logic [2:0] boot = 3'h0;
  int n_tests = 0, miscompares = 0, cycles = 0;
  status_summary_registers dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .general_input_level(general_input_levels), .alarm_event(alarm_event),
    .boot_crc_mismatch(boot[2]), .boot_read_error(boot[1]),
    .boot_read_complete(boot[0]), .irq_pin_n(irq_pin_n));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One access; read data lands one cycle after the request.
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_write, reg_read} = {a, d, w, !w};
    @(negedge clk);
    {reg_write, reg_read} = 2'b00;
    q = reg_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_gpi;
    general_input_levels = 4'ha;
    acc(0, 16'h020c, 8'h00);
    `CK(q, 8'h0a)
    general_input_levels = 4'h5;
    acc(0, 16'h020c, 8'h00);
    `CK(q, 8'h05)
    acc(0, 16'h0212, 8'h00);
    `CK(q, 8'h00)
    $display("input test done");
  endtask
  task automatic t_irq;
    acc(1, 16'h0079, 8'h01);
    alarm_event = 8'h02;
    idle(3);
    alarm_event = 8'h00;
    `CK(irq_pin_n, 1'b1)
    alarm_event = 8'h01;
    idle(3);
    alarm_event = 8'h00;
    `CK(irq_pin_n, 1'b0)
    acc(0, 16'h020d, 8'h00);
    `CK(q, 8'h01)
    acc(1, 16'h0200, 8'h01);
    idle(2);
    `CK(irq_pin_n, 1'b1)
    acc(0, 16'h020d, 8'h00);
    `CK(q, 8'h00)
    acc(0, 16'h0200, 8'h00);
    `CK(q, 8'h02)
    alarm_event = 8'h04;
    acc(1, 16'h0200, 8'h04);
    alarm_event = 8'h00;
    acc(0, 16'h0200, 8'h00);
    `CK(q, 8'h06)
    $display("interrupt test done");
  endtask
  task automatic t_boot;
    acc(0, 16'h0211, 8'h00);
    `CK(q, 8'h00)
    boot = 3'h4;
    idle(1);
    boot = 3'h0;
    acc(0, 16'h0210, 8'h00);
    `CK(q, 8'h02)
    boot = 3'h3;
    idle(1);
    boot = 3'h0;
    acc(1, 16'h0210, 8'h03);
    acc(0, 16'h0210, 8'h00);
    `CK(q, 8'h03)
    acc(0, 16'h0211, 8'h00);
    `CK(q, 8'h01)
    reset = 1;
    idle(2);
    reset = 0;
    acc(0, 16'h0210, 8'h00);
    `CK(q, 8'h00)
    acc(0, 16'h0211, 8'h00);
    `CK(q, 8'h00)
    $display("boot test done");
  endtask
  initial begin
    idle(8);
    reset = 0;
    t_gpi();
    t_irq();
    t_boot();
    results();
  end
endmodule // status_summary_registers_bench
bind status_summary_registers status_summary_checker chk (.clk(clk), .reset(reset),
  .reg_write(reg_write), .reg_read(reg_read), .irq_pin_n(irq_pin_n),
  .boot_crc_mismatch(boot_crc_mismatch), .boot_read_error(boot_read_error),
  .boot_read_complete(boot_read_complete), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .alarm_event(alarm_event),
  .general_input_level(general_input_level));
`default_nettype wire
